// ===== rtl/icd_pkg.sv
/*
  constants, state encoding and carrier structs for the idle clock divider and
  wake-up controller. assumes a single 100 MHz input clock and an active-low
  asynchronous reset supplied by the surrounding core.
*/
// Functional notes
// (R1) idle instruction stops issue and enters low power until an interrupt arrives
// (R2) wake-up services the interrupt, then resumes at the instruction after idle
// (R3) divided idle slows the core clock to input rate divided by n from instruction
// (R4) divisor limited to 16, 32, 64 or 128
// (R5) serial, clock output and timer clocks slowed by the same divisor
// (R6) after an enabled interrupt in divided idle, wake within n input-clock cycles
// (R7) standard idle responds in one cycle; divided idle adds n
// (R8) external serial clock source must not interrupt faster than wake-up allows
// (R9) legacy build supports only standard idle, no divided variant
// (R10) leaving divided idle restores divide-by-one on all derived clocks
package icd_pkg;

  // ****************************************************************
  // divisor selection and timing
  // ****************************************************************
  localparam logic [1:0] ICD_SEL_DIV16 = 2'h0;
  localparam logic [1:0] ICD_SEL_DIV32 = 2'h1;
  localparam logic [1:0] ICD_SEL_DIV64 = 2'h2;
  localparam logic [1:0] ICD_SEL_DIV128 = 2'h3;
  localparam int ICD_CNT_W = 7;
  localparam logic [ICD_CNT_W-1:0] ICD_TERM_DIV1 = 7'h00;
  localparam logic [ICD_CNT_W-1:0] ICD_TERM_DIV16 = 7'h0F;
  localparam logic [ICD_CNT_W-1:0] ICD_TERM_DIV32 = 7'h1F;
  localparam logic [ICD_CNT_W-1:0] ICD_TERM_DIV64 = 7'h3F;
  localparam logic [ICD_CNT_W-1:0] ICD_TERM_DIV128 = 7'h7F;
  localparam int ICD_STD_WAKE_NS = 10;
  localparam int ICD_CLK_PERIOD_NS = 10;
  localparam int ICD_STD_WAKE_CYC = (ICD_STD_WAKE_NS + ICD_CLK_PERIOD_NS - 1) / ICD_CLK_PERIOD_NS;

  // ****************************************************************
  // state and carriers
  // ****************************************************************
  typedef enum logic [1:0] {
    ICD_RUN = 2'h0,
    ICD_IDLE = 2'h1,
    ICD_WAKE = 2'h3
  } icd_state_e;

  typedef struct packed {
    logic idle_exec;
    logic div_en;
    logic [1:0] div_sel;
  } icd_cmd_s;

  typedef struct packed {
    logic core_tick;
    logic sclk_tick;
    logic processor_clock_output_tick;
    logic timer_tick;
  } icd_ticks_s;

endpackage

// ===== rtl/icd_divider.sv
/*
  divide-by-n tick generator. emits a one-cycle tick every term+1 input-clock
  cycles; term of zero gives a tick on every cycle. term changes take effect
  at once; a count at or above the new term ticks and restarts at zero, as restart_in does without the tick.
*/
`timescale 1ns/1ps
`default_nettype none
module icd_divider
  import icd_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [ICD_CNT_W-1:0] term_in,
  input wire logic restart_in,
  output logic tick_out
);

  logic [ICD_CNT_W-1:0] cnt_reg;
  logic [ICD_CNT_W-1:0] cnt_next;
  wire at_term = (cnt_reg >= term_in);

  assign cnt_next = (restart_in || at_term) ? ICD_TERM_DIV1 : ICD_CNT_W'(cnt_reg + 1'b1);
  assign tick_out = at_term && !restart_in;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_reg <= ICD_TERM_DIV1;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/icd_idle_ctrl.sv
/*
  idle and divided-idle controller. sits between the sequencer (idle command,
  issue stall, resume) and the clock tree (core, serial, clock output and
  timer enables). assumes interrupt_in is already masked to enabled sources
  and held until acknowledged by the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
module icd_idle_ctrl
  import icd_pkg::*;
#(
  parameter bit LEGACY_ONLY = 1'b0
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire icd_cmd_s cmd_in,
  input wire logic interrupt_in,
  output logic issue_stall_out,
  output logic service_irq_out,
  output logic low_power_out,
  output icd_ticks_s ticks_out,
  output logic [ICD_CNT_W-1:0] divisor_term_out
);

  // ****************************************************************
  // state
  // ****************************************************************
  icd_state_e state_reg;
  icd_state_e state_next;
  logic [ICD_CNT_W-1:0] term_reg;
  logic [ICD_CNT_W-1:0] term_next;
  logic stall_reg;
  logic service_reg;
  logic tick_hold_reg;
  icd_ticks_s ticks_reg;
  logic div_tick;

  // ****************************************************************
  // decode
  // ****************************************************************
  // legacy build ignores the divide request entirely
  wire div_req = cmd_in.div_en && !LEGACY_ONLY;  // [R9]
  wire [ICD_CNT_W-1:0] sel_term =
    (cmd_in.div_sel == ICD_SEL_DIV16) ? ICD_TERM_DIV16 :
    (cmd_in.div_sel == ICD_SEL_DIV32) ? ICD_TERM_DIV32 :
    (cmd_in.div_sel == ICD_SEL_DIV64) ? ICD_TERM_DIV64 : ICD_TERM_DIV128;  // [R4]
  wire enter_idle = (state_reg == ICD_RUN) && cmd_in.idle_exec;
  wire wake_ok = (state_reg == ICD_IDLE) && interrupt_in && div_tick;  // [R6] [R7]
  wire restart_div = enter_idle || (state_reg == ICD_WAKE);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    term_next = term_reg;
    case (state_reg)
      ICD_RUN: begin
        if (cmd_in.idle_exec) begin
          state_next = ICD_IDLE;  // [R1]
          term_next = div_req ? sel_term : ICD_TERM_DIV1;  // [R3]
        end
      end
      ICD_IDLE: begin
        // the wake check waits for the slow tick, so an interrupt waits at most n cycles
        if (wake_ok) begin
          state_next = ICD_WAKE;
          term_next = ICD_TERM_DIV1;  // [R10]
        end
      end
      ICD_WAKE: begin
        state_next = ICD_RUN;  // [R2]
      end
      default: begin
        state_next = ICD_RUN;
        term_next = ICD_TERM_DIV1;
      end
    endcase
  end

  // ****************************************************************
  // divided tick source shared by all derived clocks
  // ****************************************************************
  icd_divider u_div (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .term_in(term_reg),
    .restart_in(restart_div),
    .tick_out(div_tick)
  );

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= ICD_RUN;
      term_reg <= ICD_TERM_DIV1;
      stall_reg <= 1'b0;
      service_reg <= 1'b0;
      tick_hold_reg <= 1'b0;
      ticks_reg <= '0;
    end else begin
      state_reg <= state_next;
      term_reg <= term_next;
      stall_reg <= (state_next == ICD_IDLE);  // [R1]
      // one-cycle pulse telling the sequencer to vector, then fall through past idle
      service_reg <= (state_next == ICD_WAKE);  // [R2]
      tick_hold_reg <= div_tick;
      // all derived clocks take the same enable so their ratio is common
      ticks_reg <= {4{div_tick}};  // [R5]
    end
  end

  assign issue_stall_out = stall_reg;
  assign service_irq_out = service_reg;
  assign low_power_out = stall_reg;
  assign ticks_out = ticks_reg;
  assign divisor_term_out = term_reg;

endmodule
`default_nettype wire

// ===== bench/icd_sva.sv
/* port checks for icd_idle_ctrl; assumes the interrupt is held until serviced */
`timescale 1ns/1ps
`default_nettype none
module icd_sva
  import icd_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire icd_cmd_s cmd_in,
  input wire logic interrupt_in,
  input wire logic issue_stall_out,
  input wire logic service_irq_out,
  input wire logic low_power_out,
  input wire icd_ticks_s ticks_out,
  input wire logic [ICD_CNT_W-1:0] divisor_term_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_idle_entry: assert property (!issue_stall_out && !$past(issue_stall_out) && cmd_in.idle_exec
    |=> issue_stall_out) else $error("idle not entered");
  a_stall_hold: assert property (issue_stall_out && !interrupt_in |=> issue_stall_out)
    else $error("idle left early");
  a_low_power: assert property (low_power_out == issue_stall_out)
    else $error("low power differs from stall");
  a_one_pulse: assert property (service_irq_out |=> !service_irq_out)
    else $error("service too long");
  a_wake_std: assert property (issue_stall_out && interrupt_in && divisor_term_out == 7'h00
    |-> ##[1:3] service_irq_out) else $error("slow wake");
  a_wake_div: assert property (issue_stall_out && interrupt_in |-> ##[1:130] service_irq_out)
    else $error("divided wake late");
  a_ticks_same: assert property (ticks_out == 4'h0 || ticks_out == 4'hF)
    else $error("ticks differ");
  a_slow_tick: assert property (issue_stall_out && !interrupt_in && ticks_out.core_tick && divisor_term_out != 7'h00
    |=> (!ticks_out.core_tick) [*8]) else $error("tick too soon");
  a_full_rate: assert property ((!issue_stall_out) [*3] |-> ticks_out.core_tick && divisor_term_out == 7'h00)
    else $error("not full rate");
endmodule
bind icd_idle_ctrl icd_sva u_sva (.clk_in(clk_in), .reset_n_in(reset_n_in), .cmd_in(cmd_in),
  .interrupt_in(interrupt_in), .issue_stall_out(issue_stall_out), .service_irq_out(service_irq_out),
  .low_power_out(low_power_out),
  .ticks_out(ticks_out), .divisor_term_out(divisor_term_out));
`default_nettype wire

// ===== bench/icd_seq_model.sv
/* sequencer interrupt side; holds a raised interrupt until serviced */
`timescale 1ns/1ps
`default_nettype none
module icd_seq_model (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic raise_in,
  input wire logic service_in,
  output logic irq_out
);
  // one interrupt at a time, so none is raised faster than serviced
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_out <= 1'b0;
    end else if (service_in) begin
      irq_out <= 1'b0;
    end else if (raise_in) begin
      irq_out <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
/* bench for icd_idle_ctrl; needs icd_pkg, icd_seq_model and icd_sva */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t %0h %0h", $time, a, b); end end
module testbench;
  import icd_pkg::*;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic raise = 1'b0;
  icd_cmd_s cmd = '0;
  logic irq, stall, svc, lp;
  icd_ticks_s ticks;
  logic [ICD_CNT_W-1:0] term, term_leg;
  int error_cnt = 0;
  int n_checks = 0;
  always #5 clk_in = ~clk_in;
  icd_seq_model seq (.clk_in(clk_in), .reset_n_in(reset_n_in), .raise_in(raise), .service_in(svc), .irq_out(irq));
  icd_idle_ctrl dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .cmd_in(cmd), .interrupt_in(irq),
    .issue_stall_out(stall), .service_irq_out(svc), .low_power_out(lp), .ticks_out(ticks), .divisor_term_out(term));
  icd_idle_ctrl #(.LEGACY_ONLY(1'b1)) dut_leg (.clk_in(clk_in), .reset_n_in(reset_n_in), .cmd_in(cmd),
    .interrupt_in(irq), .issue_stall_out(), .service_irq_out(), .low_power_out(), .ticks_out(),
    .divisor_term_out(term_leg));
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one idle entry, tick count while idle, then wake and back to full rate
  task automatic idle_run(input logic div, input logic [1:0] sel);
    int n;
    int k;
    n = div ? 16 << sel : 1;
    k = 0;
    cmd = '{1'b1, div, sel};
    step(1);
    cmd = '0;
    `CHK(stall, 1'b1)
    `CHK(lp, 1'b1)
    `CHK(term, 7'(n - 1))
    `CHK(term_leg, 7'h00)
    repeat (2 * n) begin
      step(1);
      k += ticks.core_tick;
    end
    `CHK(k, 2)
    raise = 1'b1;
    step(1);
    raise = 1'b0;
    k = 0;
    while (!svc && k < 200) begin
      step(1);
      k++;
    end
    `CHK(k <= n + 2, 1'b1)
    if (k >= 200) complete_run();
    step(3);
    `CHK(ticks, 4'hF)
    `CHK({stall, term}, 8'h00)
    `CHK(lp, 1'b0)
  endtask
  initial begin
    step(3);
    reset_n_in = 1'b1;
    idle_run(1'b0, 2'h0);
    for (int s = 0; s < 4; s++) begin
      idle_run(1'b1, 2'(s));
    end
    complete_run();
  end
endmodule
`default_nettype wire
